// file: core/art_defines.svh
// Summary of operation
// - result valid once conversion-done flag set
// - single-ended code unsigned, 0x000 to 0x3ff
// - differential code two's complement, 0x200..0x1ff
// - top result bit marks negative difference
// - differential extremes saturate, small negative 0x3ff
// - sensor select enables driver; conversions started before the 50-cycle settle discarded
// - input-short control ties differential inputs together
// - revision byte picks the temperature formula
// - old and new Celsius formulas as given
// - slope calibration unsigned 8-bit, 1/128 units
// - bias calibration signed 7-bit, sign-extended
// - alignment change rearranges bytes at once
// - done flag set on update, cleared vector/write-one
`ifndef ART_DEFINES_SVH
`define ART_DEFINES_SVH

`define ART_OFF_CTRL   8'h00
`define ART_OFF_RESULT 8'h04
`define ART_OFF_STAT   8'h08
`define ART_OFF_MASK   8'h0c
`define ART_OFF_CAL    8'h10
`define ART_OFF_TEMP   8'h14

`define ART_CTRL_LEFT  5
`define ART_CTRL_DIFF  6
`define ART_CTRL_SHORT 7
`define ART_CTRL_RST   8'h00
`define ART_CAL_RST    23'h000000

`define ART_ST_DONE    0
`define ART_ST_TEMP    1
`define ART_ST_SKIP    2

`define ART_CH_TEMP    5'h0b
`define ART_SE_MAX     10'h3ff
`define ART_DF_MAX     10'h1ff
`define ART_DF_MIN     10'h200
`define ART_OLD_BASE   24'sd273
`define ART_NEW_BASE   24'sd298
`define ART_NEW_ADD    24'sd25
`define ART_DIV_SHIFT  7

`define ART_CLK_MHZ    25
`define ART_SETTLE_NS  2000
`define ART_SETTLE_CYC ((`ART_SETTLE_NS * `ART_CLK_MHZ + 999) / 1000)

`endif

// file: core/art_pkg.sv
package art_pkg;
  typedef logic signed [11:0] art_raw_t;
  typedef logic [9:0]         art_code_t;
  typedef enum logic [1:0] {ART_TS_OFF, ART_TS_SETTLE, ART_TS_READY} art_ts_e;
endpackage : art_pkg

// file: core/art_top.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "art_defines.svh"
module art_top (
  input  logic             pclk,
  input  logic             presetn,
  input  logic             psel,
  input  logic             penable,
  input  logic             pwrite,
  input  logic [7:0]       paddr,
  input  logic [31:0]      pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  logic             conv_start,
  input  logic             conv_done,
  input  art_pkg::art_raw_t conv_code,
  input  logic             vector_ack,
  output logic [4:0]       channel_select_field,
  output logic             diff_select,
  output logic             amp_input_short,
  output logic             sensor_drv_en,
  output logic             irq
);
  import art_pkg::*;

  // new-formula revision code; value is arbitrary
  parameter logic [7:0] REV_NEW_CODE = 8'h5a;

  logic [7:0]     ctrl_q;
  logic [2:0]     stat_q;
  logic [2:0]     mask_q;
  logic [22:0]    cal_q;
  art_code_t      res_q;
  logic [15:0]    temp_q;
  art_ts_e        ts_q;
  logic [5:0]     settle_q;
  logic           sample_ok_q;
  logic           wr_en;
  logic           is_temp;
  art_code_t      code_sat;
  logic [7:0]     lo_byte;
  logic [7:0]     hi_byte;

  function automatic art_code_t sat_code(input art_raw_t v, input logic diff);
    art_code_t r;
    r = v[9:0];
    if (diff)
    begin
      if (v > 12'sd511)
        r = `ART_DF_MAX;
      else if (v < -12'sd512)
        r = `ART_DF_MIN;
    end
    else
    begin
      if (v < 12'sd0)
        r = 10'h000;
      else if (v > 12'sd1023)
        r = `ART_SE_MAX;
    end
    return r;
  endfunction : sat_code

  function automatic logic [15:0] calc_temp(input art_code_t raw, input logic [7:0] gain,
                                            input logic [6:0] off, input logic newf);
    logic signed [23:0] soff;
    logic signed [23:0] diffv;
    logic signed [23:0] prod;
    logic signed [23:0] q;
    soff = {{17{off[6]}}, off};
    if (newf)
      diffv = $signed({14'h0000, raw}) - (`ART_NEW_BASE - soff);
    else
      diffv = $signed({14'h0000, raw}) - `ART_OLD_BASE;
    prod = diffv * $signed({16'h0000, gain});
    q = prod >>> `ART_DIV_SHIFT;
    q = newf ? q + `ART_NEW_ADD : q + soff;
    return q[15:0];
  endfunction : calc_temp

  // write commits on the edge that samples pready high, request still held
  assign wr_en    = psel && penable && pwrite && pready;
  assign is_temp  = (ctrl_q[4:0] == `ART_CH_TEMP) && !ctrl_q[`ART_CTRL_DIFF];
  assign code_sat = sat_code(conv_code, ctrl_q[`ART_CTRL_DIFF]);

  // bytes built from the live alignment bit, never stored twice
  always_comb
  begin
    if (ctrl_q[`ART_CTRL_LEFT])
    begin
      hi_byte = res_q[9:2];
      lo_byte = {res_q[1:0], 6'h00};
    end
    else
    begin
      hi_byte = {6'h00, res_q[9:8]};
      lo_byte = res_q[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `ART_CTRL_RST;
    else if (wr_en && paddr == `ART_OFF_CTRL)
      ctrl_q <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_q <= 3'h0;
    else if (wr_en && paddr == `ART_OFF_MASK)
      mask_q <= pwdata[2:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_q <= `ART_CAL_RST;
    else if (wr_en && paddr == `ART_OFF_CAL)
      cal_q <= pwdata[22:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      res_q <= 10'h000;
    else if (conv_done)
      res_q <= code_sat;
  end

  // sensor driver must settle before the sample phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ts_q     <= ART_TS_OFF;
      settle_q <= 6'h00;
    end
    else if (!is_temp)
    begin
      ts_q     <= ART_TS_OFF;
      settle_q <= 6'h00;
    end
    else
    begin
      case (ts_q)
        ART_TS_OFF:
        begin
          ts_q     <= ART_TS_SETTLE;
          settle_q <= 6'h00;
        end
        ART_TS_SETTLE:
        begin
          if (settle_q == 6'(`ART_SETTLE_CYC - 1))
            ts_q <= ART_TS_READY;
          else
            settle_q <= settle_q + 6'h01;
        end
        ART_TS_READY:
          ts_q <= ART_TS_READY;
        default:
          ts_q <= ART_TS_OFF;
      endcase
    end
  end

  // early selection during the previous conversion is honoured here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample_ok_q <= 1'b0;
    else if (conv_start)
      sample_ok_q <= (ts_q == ART_TS_READY);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      temp_q <= 16'h0000;
    else if (conv_done && is_temp && sample_ok_q)
      temp_q <= calc_temp(code_sat, cal_q[15:8], cal_q[22:16],
                          cal_q[7:0] == REV_NEW_CODE);
  end

  // set beats any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= 3'h0;
    else
    begin
      stat_q[`ART_ST_DONE] <= conv_done || (stat_q[`ART_ST_DONE] && !vector_ack &&
                              !(wr_en && paddr == `ART_OFF_STAT && pwdata[`ART_ST_DONE]));
      stat_q[`ART_ST_TEMP] <= (conv_done && is_temp && sample_ok_q) || (stat_q[`ART_ST_TEMP] &&
                              !(wr_en && paddr == `ART_OFF_STAT && pwdata[`ART_ST_TEMP]));
      stat_q[`ART_ST_SKIP] <= (conv_done && is_temp && !sample_ok_q) || (stat_q[`ART_ST_SKIP] &&
                              !(wr_en && paddr == `ART_OFF_STAT && pwdata[`ART_ST_SKIP]));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(stat_q & mask_q);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_select_field <= 5'h00;
      diff_select          <= 1'b0;
      amp_input_short      <= 1'b0;
      sensor_drv_en        <= 1'b0;
    end
    else
    begin
      channel_select_field <= ctrl_q[4:0];
      diff_select          <= ctrl_q[`ART_CTRL_DIFF];
      amp_input_short      <= ctrl_q[`ART_CTRL_SHORT];
      sensor_drv_en        <= is_temp;
    end
  end

  // one wait state on every access keeps decode off the critical path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (psel && penable && !pready)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      case (paddr)
        `ART_OFF_CTRL:   prdata <= {24'h000000, ctrl_q};
        `ART_OFF_RESULT: prdata <= {16'h0000, hi_byte, lo_byte};
        `ART_OFF_STAT:   prdata <= {29'h00000000, stat_q};
        `ART_OFF_MASK:   prdata <= {29'h00000000, mask_q};
        `ART_OFF_CAL:    prdata <= {9'h000, cal_q};
        `ART_OFF_TEMP:   prdata <= {16'h0000, temp_q};
        default:         pslverr <= 1'b1;
      endcase
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_temp_sel;
    is_temp && !$past(is_temp);
  endsequence

  sequence s_settled;
    ts_q == ART_TS_READY;
  endsequence

  a_done_flag_set: assert property (conv_done |=> stat_q[`ART_ST_DONE] && res_q == $past(code_sat))
    else $error("done flag or result missing after conversion");

  a_se_top_code: assert property (conv_done && !ctrl_q[`ART_CTRL_DIFF] && conv_code > 12'sd1023
                                 |=> res_q == 10'h3ff)
    else $error("single-ended code not clamped to full scale");

  a_diff_sat_lo: assert property (conv_done && ctrl_q[`ART_CTRL_DIFF] && conv_code < -12'sd512
                                 |=> res_q == 10'h200)
    else $error("differential code not clamped low");

  a_diff_sign_bit: assert property (conv_done && ctrl_q[`ART_CTRL_DIFF]
                                   |=> res_q[9] == $past(conv_code[11]))
    else $error("sign bit disagrees with difference");

  a_settle_wait: assert property (s_temp_sel |=> !(ts_q == ART_TS_READY) [*8])
    else $error("sensor ready before settle time");

  a_settle_done: assert property (s_temp_sel ##1 (is_temp [*1]) |-> ##[50:52] s_settled or !is_temp)
    else $error("sensor never became ready");

  a_skip_first: assert property (conv_done && is_temp && !sample_ok_q
                                |=> $stable(temp_q) && stat_q[`ART_ST_SKIP])
    else $error("unsettled temperature result not discarded");

  a_vector_clear: assert property (vector_ack && !conv_done |=> !stat_q[`ART_ST_DONE])
    else $error("vector did not clear done flag");

  a_align_left: assert property (ctrl_q[`ART_CTRL_LEFT] |-> hi_byte == res_q[9:2] && lo_byte[5:0] == 6'h00)
    else $error("left alignment layout wrong");

  a_short_follow: assert property ($rose(ctrl_q[`ART_CTRL_SHORT]) |=> amp_input_short)
    else $error("input short not applied");

  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one cycle");

endmodule : art_top

// file: sim/art_core_model.sv
`timescale 1ns/1ps
module art_core_model #(parameter int LAT = 60) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              go,
  input  wire art_pkg::art_raw_t code,
  output logic                   conv_start,
  output logic                   conv_done,
  output art_pkg::art_raw_t      conv_code
);
  import art_pkg::*;
  logic [7:0] cnt_q;
  art_raw_t   hold_q;
  // single conversions only, one per go pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q      <= 8'h00;
      hold_q     <= '0;
      conv_start <= 1'b0;
      conv_done  <= 1'b0;
      conv_code  <= '0;
    end
    else
    begin
      conv_start <= go;
      conv_done  <= (cnt_q == 8'h01);
      if (go)
        cnt_q <= 8'(LAT);
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
      if (go)
        hold_q <= code;
      // code only valid with done; toggles otherwise so stale data is not trusted
      conv_code <= (cnt_q == 8'h01) ? hold_q : ~conv_code;
    end
  end
endmodule : art_core_model

// file: sim/art_top_tb.sv
`timescale 1ns/1ps
module art_top_tb;
  import art_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, vector_ack, go, pready, pslverr;
  logic conv_start, conv_done, diff_select, amp_input_short, sensor_drv_en, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] channel_select_field;
  art_raw_t conv_code, code;
  int failures, samples_checked, cyc;
  logic e;
  // per-chip user calibration; values are arbitrary
  localparam logic [31:0] user_bias_value = 32'd100;
  localparam logic [31:0] user_cal_coef   = 32'd4;
  art_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_done(conv_done), .conv_code(conv_code), .vector_ack(vector_ack),
    .channel_select_field(channel_select_field), .diff_select(diff_select),
    .amp_input_short(amp_input_short), .sensor_drv_en(sensor_drv_en), .irq(irq));
  art_core_model u_core (.pclk(pclk), .presetn(presetn), .go(go), .code(code),
    .conv_start(conv_start), .conv_done(conv_done), .conv_code(conv_code));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      failures++;
      $display("Error pready expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask : apb
  // returns two edges after done so result and irq have landed
  task automatic wait_done;
    int n;
    n = 0;
    while (conv_done !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (conv_done !== 1'b1)
    begin
      failures++;
      $display("Error conv_done expected 1 seen %b", conv_done);
    end
    repeat (2) @(posedge pclk);
  endtask : wait_done
  // one conversion
  task automatic conv(input art_raw_t c);
    code <= c;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    wait_done;
  endtask : conv
  task automatic t_reset;
    apb(0, 8'h00, 0); chk("ctrl_rst", 0, q);
    apb(0, 8'h08, 0); chk("stat_rst", 0, q);
    $display("reset test done");
  endtask : t_reset
  // sensor picked just after the previous start, so the next conversion is already settled
  task automatic t_early;
    logic [31:0] rv;
    apb(1, 8'h00, 32'h0000_0000);
    apb(1, 8'h08, 32'h0000_0007);
    code <= 12'sd420;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    apb(1, 8'h00, 32'h0000_000b);
    wait_done;
    apb(0, 8'h08, 0); chk("early_skip", 3'b101, q[2:0]);
    apb(1, 8'h08, 32'h7);
    conv(12'sd420);
    apb(0, 8'h08, 0); chk("early_ok", 3'b011, q[2:0]);
    apb(0, 8'h14, 0); chk("t_early", 32'd144, {16'h0, q[15:0]});
    apb(0, 8'h04, 0);
    rv = {16'h0000, q[15:8], q[7:0]};
    chk("user_cal", (32'd420 - user_bias_value) / user_cal_coef, (rv - user_bias_value) / user_cal_coef);
    $display("early select test done");
  endtask : t_early
  task automatic t_formats;
    apb(1, 8'h00, 32'h0000_0000);
    apb(1, 8'h0c, 32'h0000_0001);
    conv(12'sd1023);
    apb(0, 8'h04, 0); chk("se_full", 32'h0000_03ff, q);
    chk("irq_set", 1, irq);
    apb(0, 8'h08, 0); chk("done", 1, q[0]);
    apb(1, 8'h08, 32'h1);
    @(posedge pclk);
    chk("irq_clr", 0, irq);
    conv(12'sd1500);
    apb(0, 8'h04, 0); chk("se_clamp", 32'h0000_03ff, q);
    apb(1, 8'h00, 32'h0000_0040);
    conv(-12'sd400);
    apb(0, 8'h04, 0); chk("df_neg", 32'h0000_0270, q);
    chk("sign", 1, q[9]);
    apb(1, 8'h00, 32'h0000_0060);
    apb(0, 8'h04, 0); chk("left", 32'h0000_9c00, q);
    apb(1, 8'h00, 32'h0000_00c3);
    @(posedge pclk);
    chk("short", 1, amp_input_short);
    chk("chan", 3, channel_select_field);
    chk("diff", 1, diff_select);
    conv(-12'sd600);
    apb(0, 8'h04, 0); chk("df_min", 32'h0000_0200, q);
    conv(12'sd600);
    apb(0, 8'h04, 0); chk("df_max", 32'h0000_01ff, q);
    conv(-12'sd1);
    apb(0, 8'h04, 0); chk("df_m1", 32'h0000_03ff, q);
    vector_ack <= 1'b1;
    @(posedge pclk);
    vector_ack <= 1'b0;
    @(posedge pclk);
    apb(0, 8'h08, 0); chk("vec_clr", 0, q[0]);
    apb(0, 8'h30, 0); chk("unmapped", 1, e);
    $display("formats test done");
  endtask : t_formats
  task automatic t_temp;
    apb(1, 8'h10, 32'h0005_8000);
    apb(1, 8'h00, 32'h0000_000b);
    repeat (2) @(posedge pclk);
    chk("drv_en", 1, sensor_drv_en);
    conv(12'sd400);
    apb(0, 8'h08, 0); chk("discard", 3'b101, q[2:0]);
    apb(1, 8'h08, 32'h7);
    conv(12'sd400);
    apb(0, 8'h08, 0); chk("tvalid", 3'b011, q[2:0]);
    apb(0, 8'h14, 0); chk("t_old", 32'd132, {16'h0, q[15:0]});
    apb(1, 8'h10, 32'h007d_805a);
    conv(12'sd400);
    apb(0, 8'h14, 0); chk("t_new", 32'd124, {16'h0, q[15:0]});
    $display("temperature test done");
  endtask : t_temp
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, vector_ack, go} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    code = '0;
    failures = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_formats;
    t_temp;
    t_early;
    results;
  end
  // hang guard: the tests need well under 3000 cycles
  initial
  begin
    cyc = 0;
    while (cyc < 8000)
    begin
      @(posedge pclk);
      cyc++;
    end
    failures++;
    results;
  end
endmodule : art_top_tb
